/* File: common/qcil_consts.svh */
// Constants of the quadrature counter and request logic: offsets, fields, reset values.
// Assumes inclusion by the package and the core; holds definitions only.
`ifndef QCIL_CONSTS_SVH
`define QCIL_CONSTS_SVH

// Register offsets inside one channel window (byte addresses)
`define QCIL_OFF_CTRL 5'h00
`define QCIL_OFF_FLAG 5'h04
`define QCIL_OFF_IEN 5'h08
`define QCIL_OFF_COUNT 5'h0C
`define QCIL_OFF_MATCH_A 5'h10
`define QCIL_OFF_MATCH_B 5'h14
`define QCIL_OFF_MATCH_C 5'h18
`define QCIL_OFF_MATCH_D 5'h1C
// Channel windows are 32 bytes apart; channel index sits in these address bits
`define QCIL_CH_MSB 6
`define QCIL_CH_LSB 5

// Field positions in the flag and enable registers
`define QCIL_BIT_MATCH_A 0
`define QCIL_BIT_OVERFLOW 4
`define QCIL_BIT_UNDERFLOW 5
`define QCIL_BIT_CONV_TRIG 7

// Implemented flag bits: channel 0 has four match registers, no underflow
`define QCIL_FLAG_MASK_CH0 6'h1F
`define QCIL_FLAG_MASK_PH 6'h33

// Count mode codes in the control register
`define QCIL_MODE_OFF 3'h0
`define QCIL_MODE_PH1 3'h1
`define QCIL_MODE_PH2 3'h2
`define QCIL_MODE_PH3 3'h3
`define QCIL_MODE_PH4 3'h4

// Reset values and the count maximum
`define QCIL_RST_COUNT 16'h0000
`define QCIL_RST_MATCH 16'hFFFF
`define QCIL_COUNT_MAX 16'hFFFF

`endif

/* File: common/qcil_pkg.sv */
// Types of the quadrature counter and request logic.
// Assumes the constants header sits beside it in common/.
`include "qcil_consts.svh"

package qcil_pkg;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } qcil_wb_req_t;

  // Whole state of the core
  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] old;
    logic [2:0][2:0] mode;
    logic [2:0][5:0] flag;
    logic [2:0][7:0] ien;
    logic [2:0][15:0] cnt;
    logic [2:0][3:0][15:0] mreg;
    logic [12:0] irq;
    logic [7:0] xreq;
    logic [2:0] adc;
    logic irq_any;
    logic [3:0] irq_top;
    logic ack;
    logic [31:0] dat;
  } qcil_state_t;

endpackage : qcil_pkg

/* File: core/qcil_top.sv */
// Quadrature counter with match flags, interrupt, transfer and converter requests.
// Assumes a classic Wishbone master on clk_i and asynchronous phase pins.
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "qcil_consts.svh"

module qcil_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire qcil_pkg::qcil_wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic ext_clk_in_a_i,
  input wire logic ext_clk_in_b_i,
  input wire logic ext_clk_in_c_i,
  input wire logic ext_clk_in_d_i,
  input wire logic [7:0] xfer_ack_i,
  output logic [12:0] irq_o,
  output logic irq_any_o,
  output logic [3:0] irq_top_o,
  output logic [7:0] xfer_req_o,
  output logic [2:0] adc_start_o
);
  import qcil_pkg::*;

  qcil_state_t q;
  qcil_state_t n;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : wmerge

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic req;
    logic wr;
    logic [1:0] wch;
    logic [4:0] woff;
    logic a;
    logic b;
    logic ar;
    logic af;
    logic br;
    logic bf;
    logic up;
    logic dn;
    logic ov;
    logic un;
    logic cwr;
    logic [3:0] mwr;
    logic [5:0] ev;
    logic [5:0] msk;
    logic [5:0] clr;
    logic [7:0] xa;
    logic [31:0] rd;
    req = 1'b0;
    wr = 1'b0;
    wch = 2'h0;
    woff = 5'h00;
    a = 1'b0;
    b = 1'b0;
    ar = 1'b0;
    af = 1'b0;
    br = 1'b0;
    bf = 1'b0;
    up = 1'b0;
    dn = 1'b0;
    ov = 1'b0;
    un = 1'b0;
    cwr = 1'b0;
    mwr = 4'h0;
    ev = 6'h00;
    msk = 6'h00;
    clr = 6'h00;
    xa = xfer_ack_i;
    rd = 32'h0000_0000;
    n = q;
    n.adc = 3'h0;

    n.sy1 = {ext_clk_in_d_i, ext_clk_in_c_i, ext_clk_in_b_i, ext_clk_in_a_i};
    n.sy2 = q.sy1;
    n.old = q.sy2;

    // Bus decode: one access per request, ack for one cycle
    req = wb_i.cyc & wb_i.stb & ~q.ack;
    wr = req & wb_i.we;
    wch = wb_i.adr[`QCIL_CH_MSB:`QCIL_CH_LSB];
    woff = wb_i.adr[4:0];
    n.ack = req;

    for (int c = 0; c < 3; c++) begin
      msk = (c == 0) ? `QCIL_FLAG_MASK_CH0 : `QCIL_FLAG_MASK_PH;
      // channel 1 on pins a,b; channel 2 on pins c,d
      if (c != 0) begin
        a = q.sy2[2 * c - 2];
        b = q.sy2[2 * c - 1];
        ar = a & ~q.old[2 * c - 2];
        af = ~a & q.old[2 * c - 2];
        br = b & ~q.old[2 * c - 1];
        bf = ~b & q.old[2 * c - 1];
      end else begin
        a = 1'b0;
        b = 1'b0;
        ar = 1'b0;
        af = 1'b0;
        br = 1'b0;
        bf = 1'b0;
      end
      up = 1'b0;
      dn = 1'b0;
      if (c == 0) begin
        up = (q.mode[c] != `QCIL_MODE_OFF);
      end else begin
        case (q.mode[c])
          `QCIL_MODE_PH1: begin
            up = (ar & ~b) | (af & b) | (br & a) | (bf & ~a);
            dn = (ar & b) | (af & ~b) | (br & ~a) | (bf & a);
          end
          `QCIL_MODE_PH2: begin
            up = af & b;
            dn = af & ~b;
          end
          // A fall up, B fall down
          `QCIL_MODE_PH3: begin
            up = af & b;
            dn = bf & a;
          end
          `QCIL_MODE_PH4: begin
            up = (br & a) | (bf & ~a);
            dn = (bf & a) | (br & ~a);
          end
          default: begin
            up = 1'b0;
            dn = 1'b0;
          end
        endcase
        if (up & dn) begin
          up = 1'b0;
          dn = 1'b0;
        end
      end

      // Software writes to this channel
      cwr = wr & (wch == 2'(c)) & (woff == `QCIL_OFF_COUNT);
      for (int r = 0; r < 4; r++) begin
        mwr[r] = wr & (wch == 2'(c)) & (woff == 5'(`QCIL_OFF_MATCH_A + 4 * r));
        if (mwr[r]) begin
          n.mreg[c][r] = wmerge(q.mreg[c][r], wb_i.dat, wb_i.sel);
        end
      end
      if (wr & (wch == 2'(c)) & (woff == `QCIL_OFF_CTRL) & wb_i.sel[0]) begin
        n.mode[c] = wb_i.dat[2:0];
      end
      if (wr & (wch == 2'(c)) & (woff == `QCIL_OFF_IEN) & wb_i.sel[0]) begin
        n.ien[c] = wb_i.dat[7:0] & {2'b10, msk};
      end

      // Counter: a software write wins over a count step and its wrap flag
      ov = 1'b0;
      un = 1'b0;
      if (cwr) begin
        n.cnt[c] = wmerge(q.cnt[c], wb_i.dat, wb_i.sel);
      end else if (up) begin
        n.cnt[c] = 16'(q.cnt[c] + 16'h0001);
        ov = (q.cnt[c] == `QCIL_COUNT_MAX);
      end else if (dn) begin
        n.cnt[c] = 16'(q.cnt[c] - 16'h0001);
        un = (q.cnt[c] == 16'h0000);
      end

      // compare match when the count steps onto a match value
      ev = 6'h00;
      for (int r = 0; r < 4; r++) begin
        ev[r] = (up | dn) & ~cwr & ~mwr[r] & (n.cnt[c] == q.mreg[c][r]);
      end
      ev[`QCIL_BIT_OVERFLOW] = ov;
      ev[`QCIL_BIT_UNDERFLOW] = un;
      ev = ev & msk;

      // write zero clears, transfer activation clears its flag
      clr = 6'h00;
      if (wr & (wch == 2'(c)) & (woff == `QCIL_OFF_FLAG) & wb_i.sel[0]) begin
        clr = ~wb_i.dat[5:0];
      end
      if (c == 0) begin
        clr[3:0] = clr[3:0] | xa[3:0];
      end else begin
        clr[1:0] = clr[1:0] | xa[2 * c + 3 -: 2];
      end
      // an event sets its flag; set wins over clear
      n.flag[c] = ((q.flag[c] & ~clr) | ev) & msk;

      // register A event with converter trigger enabled
      n.adc[c] = ev[`QCIL_BIT_MATCH_A] & q.ien[c][`QCIL_BIT_CONV_TRIG];
    end

    // each request gated by its own enable, in priority order
    n.irq = {n.flag[2][5:4] & n.ien[2][5:4], n.flag[2][1:0] & n.ien[2][1:0],
             n.flag[1][5:4] & n.ien[1][5:4], n.flag[1][1:0] & n.ien[1][1:0],
             n.flag[0][4:0] & n.ien[0][4:0]};
    // transfer starts from match requests only
    n.xreq = {n.irq[10:9], n.irq[6:5], n.irq[3:0]};
    n.irq_any = |n.irq;
    // lowest index is the highest priority
    n.irq_top = 4'hF;
    for (int i = 12; i >= 0; i--) begin
      if (n.irq[i]) begin
        n.irq_top = 4'(i);
      end
    end

    // Read data; unmapped offsets and the fourth window read zero
    if (wch != 2'h3) begin
      case (woff)
        `QCIL_OFF_CTRL: rd[2:0] = q.mode[wch];
        `QCIL_OFF_FLAG: rd[5:0] = q.flag[wch];
        `QCIL_OFF_IEN: rd[7:0] = q.ien[wch];
        `QCIL_OFF_COUNT: rd[15:0] = q.cnt[wch];
        `QCIL_OFF_MATCH_A: rd[15:0] = q.mreg[wch][0];
        `QCIL_OFF_MATCH_B: rd[15:0] = q.mreg[wch][1];
        `QCIL_OFF_MATCH_C: rd[15:0] = (wch == 2'h0) ? q.mreg[wch][2] : 16'h0000;
        `QCIL_OFF_MATCH_D: rd[15:0] = (wch == 2'h0) ? q.mreg[wch][3] : 16'h0000;
        default: rd = 32'h0000_0000;
      endcase
    end
    n.dat = (req & ~wb_i.we) ? rd : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.mreg <= {12{`QCIL_RST_MATCH}};
      q.cnt <= {3{`QCIL_RST_COUNT}};
      q.irq_top <= 4'hF;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign irq_o = q.irq;
  assign irq_any_o = q.irq_any;
  assign irq_top_o = q.irq_top;
  assign xfer_req_o = q.xreq;
  assign adc_start_o = q.adc;

endmodule : qcil_top

`default_nettype wire

/* File: testbench/qcil_properties.sv */
// Checker of the quadrature counter request outputs.
// Assumes it is bound to qcil_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module qcil_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire qcil_pkg::qcil_wb_req_t wb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [7:0] xfer_ack_i,
  input wire logic [12:0] irq_o,
  input wire logic irq_any_o,
  input wire logic [3:0] irq_top_o,
  input wire logic [7:0] xfer_req_o,
  input wire logic [2:0] adc_start_o
);
  import qcil_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer timing
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_after_req: assert property ($rose(wb_i.cyc && wb_i.stb) |=> wb_ack_o)
    else $error("ack late");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
  // Request outputs
  a_any_is_or:
    assert property (irq_any_o == (|irq_o)) else $error("any wrong");
  a_top_none: assert property (irq_o == 13'h0 |-> irq_top_o == 4'hF) else $error("top idle");
  a_top_index:
    assert property (irq_o != 13'h0 |-> irq_o[irq_top_o]
      && (irq_o & ((13'h1 << irq_top_o) - 13'h1)) == 13'h0) else $error("top wrong");
  a_xfer_map:
    assert property (xfer_req_o == {irq_o[10:9], irq_o[6:5], irq_o[3:0]})
      else $error("xfer map");
  a_adc_pulse:
    assert property (|adc_start_o |=> (adc_start_o & $past(adc_start_o)) == 3'h0)
      else $error("adc long");
  a_irq_hold:
    assert property (($past(irq_o) & ~irq_o) != 13'h0 |-> $past(wb_i.we && wb_i.stb)
      || $past(xfer_ack_i) != 8'h0) else $error("irq dropped");
  // Main scenarios
  c_underflow: cover property (irq_o[8]);
  c_adc: cover property (adc_start_o[2]);
  c_xfer_clear: cover property ($fell(irq_o[9]));
endmodule : qcil_checker
////////////////////////////////////////
bind qcil_top qcil_checker qcil_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .xfer_ack_i(xfer_ack_i), .irq_o(irq_o),
  .irq_any_o(irq_any_o), .irq_top_o(irq_top_o), .xfer_req_o(xfer_req_o),
  .adc_start_o(adc_start_o));
`default_nettype wire

/* File: testbench/qcil_enc_model.sv */
// Quadrature encoder model driving the four phase pins {d,c,b,a}.
// Assumes the bench calls mv once per step.
`timescale 1ns/1ps
`default_nettype none
module qcil_enc_model (
  input wire logic clk_i,
  output logic [3:0] ph_o
);
  initial ph_o = 4'hF;
  // Step pins after an edge, hold well over two clocks
  task automatic mv(input logic [3:0] v);
    @(posedge clk_i);
    ph_o <= v;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
  endtask : mv
endmodule : qcil_enc_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench of the quadrature counter and request logic.
// Assumes a Wishbone master here and the encoder model on the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qcil_pkg::*;
  logic clk_i, rst_i, ack, any;
  qcil_wb_req_t wb;
  logic [31:0] dat;
  logic [3:0] ph, top;
  logic [7:0] xa, xr;
  logic [12:0] irq;
  logic [2:0] adc;
  int fails, num_checks, adc_n;
  qcil_top qcil_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(ack),
    .wb_dat_o(dat), .ext_clk_in_a_i(ph[0]), .ext_clk_in_b_i(ph[1]), .ext_clk_in_c_i(ph[2]),
    .ext_clk_in_d_i(ph[3]), .xfer_ack_i(xa), .irq_o(irq), .irq_any_o(any),
    .irq_top_o(top), .xfer_req_o(xr), .adc_start_o(adc));
  qcil_enc_model qcil_enc_model_inst (.clk_i(clk_i), .ph_o(ph));
  // Clock and converter pulse counter
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // converter side: trigger source is this timer, so each pulse starts one conversion
  always @(posedge clk_i) if (adc[2] === 1'b1) adc_n <= adc_n + 1;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Classic cycle: hold until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
      output logic [31:0] q);
    @(posedge clk_i);
    wb <= '{1'b1, 1'b1, w, a, 4'h3, {16'h0000, d}};
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      fails++;
      $display("BAD t=%0t no ack", $time);
    end
    q = dat;
    wb <= '0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask : rd
  task automatic mv(input logic [3:0] v);
    qcil_enc_model_inst.mv(v);
  endtask : mv
  task automatic t_reset;
    chk(32'(top), 32'hF);
    rd(8'h2C, 32'h0);
    rd(8'h30, 32'hFFFF);
    rd(8'h60, 32'h0);
  endtask : t_reset
  task automatic t_mode2;
    wr(8'h20, 16'h0002);
    wr(8'h28, 16'h0021);
    wr(8'h30, 16'h0001);
    mv(4'hE);
    rd(8'h2C, 32'h1);
    chk(32'(irq), 32'h20);
    chk(32'(xr), 32'h10);
    chk(32'(any), 32'h1);
    wr(8'h24, 16'h0000);
    @(negedge clk_i);
    chk(32'(irq), 32'h0);
    mv(4'hF);
    mv(4'hD);
    mv(4'hC);
    rd(8'h2C, 32'h0);
    mv(4'hD);
    mv(4'hC);
    rd(8'h2C, 32'hFFFF);
    chk(32'(irq), 32'h100);
    chk(32'(xr), 32'h0);
    wr(8'h24, 16'h0000);
  endtask : t_mode2
  task automatic t_mode34;
    wr(8'h40, 16'h0003);
    mv(4'h8);
    mv(4'hC);
    mv(4'h4);
    mv(4'hC);
    mv(4'h8);
    rd(8'h4C, 32'h1);
    wr(8'h40, 16'h0004);
    mv(4'h0);
    mv(4'h4);
    mv(4'hC);
    mv(4'h4);
    rd(8'h4C, 32'h2);
    wr(8'h20, 16'h0001);
    wr(8'h2C, 16'h0000);
    mv(4'h5);
    mv(4'h7);
    rd(8'h2C, 32'h2);
    wr(8'h24, 16'h0000);
    wr(8'h20, 16'h0000);
  endtask : t_mode34
  task automatic t_adc;
    wr(8'h50, 16'h0000);
    wr(8'h4C, 16'hFFFF);
    wr(8'h48, 16'h0091);
    adc_n = 0;
    mv(4'hC);
    chk(adc_n, 1);
    chk(32'(irq), 32'hA00);
    chk(32'(top), 32'h9);
    chk(32'(xr), 32'h40);
    @(posedge clk_i);
    xa <= 8'h40;
    @(posedge clk_i);
    xa <= 8'h00;
    repeat (2) @(negedge clk_i);
    chk(32'(irq), 32'h800);
  endtask : t_adc
  task automatic end_of_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // Main sequence and watchdog
  initial begin
    rst_i = 1'b1;
    wb = '0;
    xa = 8'h00;
    adc_n = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_mode2();
    t_mode34();
    t_adc();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
